// >>> core/vss_pkg.sv
package vss_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_OFFSET_RED = 8'h10;
  localparam logic [7:0] ADDR_OFFSET_GREEN = 8'h14;
  localparam logic [7:0] ADDR_OFFSET_BLUE = 8'h18;
  localparam logic [7:0] ADDR_GAIN_RED = 8'h20;
  localparam logic [7:0] ADDR_GAIN_GREEN = 8'h24;
  localparam logic [7:0] ADDR_GAIN_BLUE = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and defaults
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MONO_LSB = 2;
  localparam int CTRL_CDS_BIT = 4;
  localparam int CTRL_COMPAT_BIT = 5;
  localparam int CTRL_AUTOCYC_BIT = 6;
  localparam int CTRL_SET_LSB = 7;
  localparam logic [7:0] OFFSET_RST = 8'h80;
  localparam logic [8:0] GAIN_RST = 9'h000;
  localparam logic [1:0] CH_RED = 2'h0;
  localparam logic [1:0] CH_GREEN = 2'h1;
  localparam logic [1:0] CH_BLUE = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LATENCY_MCLK = 7;

  typedef enum logic [1:0] {
    MODE_PIXEL3 = 2'h0,
    MODE_TWO = 2'h1,
    MODE_MONO = 2'h2,
    MODE_LINE = 2'h3
  } vss_mode_t;

  typedef struct packed {
    logic [1:0] manual_set;
    logic autocyc;
    logic compat;
    logic cds_en;
    logic [1:0] mono_sel;
    vss_mode_t mode;
  } vss_cfg_t;

  localparam vss_cfg_t CFG_RST = '{manual_set: 2'h0, autocyc: 1'b1, compat: 1'b0,
                                   cds_en: 1'b1, mono_sel: 2'h0, mode: MODE_PIXEL3};

  typedef struct packed {
    logic valid;
    logic [1:0] ch;
    logic [15:0] data;
  } vss_slot_t;

endpackage

// >>> core/vss_sequencer.sv
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module vss_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins from scanner controller
  input wire logic mclk,
  input wire logic video_sample_strobe,
  input wire logic reset_sample_strobe,
  input wire logic power_on_reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Converter side
  input wire logic [15:0] adc_result,
  output logic video_cap_connect,
  output logic reset_cap_connect,
  output logic conv_active,
  output logic [1:0] conv_channel,
  output logic [8:0] gain_code,
  output logic [7:0] offset_code,
  output logic [2:0] power_down,
  // Output data bus
  output logic [7:0] data_out,
  output logic data_valid,
  output logic [1:0] data_channel
);

  typedef struct packed {
    logic mclk_q1;
    logic mclk_q2;
    logic mclk_prev;
    logic vs_q1;
    logic vs_q2;
    logic vs_prev;
    logic rs_q1;
    logic rs_q2;
    logic rs_prev;
    logic por_q1;
    logic por_q2;
    vss_pkg::vss_cfg_t cfg;
    logic [2:0][7:0] offset;
    logic [2:0][8:0] gain;
    logic [1:0] mono_active;
    logic [1:0] line_set;
    logic fall_pend;
    logic phase;
    logic [1:0] slots_left;
    logic [1:0] next_ch;
    logic rs_arm;
    logic soft_rst;
    vss_pkg::vss_slot_t [vss_pkg::LATENCY_MCLK-1:0] pipe;
    logic [7:0] low_byte;
    logic [31:0] rdata;
    logic video_conn;
    logic reset_conn;
    logic conv_act;
    logic conv_busy;
    logic [1:0] conv_ch;
    logic [8:0] gain_c;
    logic [7:0] offset_c;
    logic [2:0] pdown;
    logic [7:0] dout;
    logic dvalid;
    logic [1:0] dch;
  } vss_state_t;

  vss_state_t s;
  vss_state_t next_s;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic vs_fall;
    logic pixel;
    logic adv;
    logic reg_rst;
    logic [1:0] ch;
    logic [1:0] set;
    logic idle;
    vss_pkg::vss_slot_t slot;
    rise = 1'b0;
    fall = 1'b0;
    vs_fall = 1'b0;
    pixel = 1'b0;
    adv = 1'b0;
    reg_rst = 1'b0;
    ch = 2'h0;
    set = 2'h0;
    idle = 1'b0;
    slot = '0;
    next_s = s;

    // Synchronisers
    next_s.mclk_q1 = mclk;
    next_s.mclk_q2 = s.mclk_q1;
    next_s.mclk_prev = s.mclk_q2;
    next_s.vs_q1 = video_sample_strobe;
    next_s.vs_q2 = s.vs_q1;
    next_s.vs_prev = s.vs_q2;
    next_s.rs_q1 = reset_sample_strobe;
    next_s.rs_q2 = s.rs_q1;
    next_s.rs_prev = s.rs_q2;
    next_s.por_q1 = power_on_reset_n;
    next_s.por_q2 = s.por_q1;

    rise = s.mclk_q2 & ~s.mclk_prev;
    fall = ~s.mclk_q2 & s.mclk_prev;
    vs_fall = s.vs_prev & ~s.vs_q2;

    pixel = rise & (s.fall_pend | vs_fall);
    if (rise) begin
      next_s.fall_pend = 1'b0;
    end else if (vs_fall) begin
      next_s.fall_pend = 1'b1;
    end

    adv = rise & (pixel | ~s.cfg.compat | s.phase);
    if (pixel) begin
      next_s.phase = 1'b0;
    end else if (rise) begin
      next_s.phase = ~s.phase;
    end

    next_s.video_conn = s.vs_q2;

    if (!s.cfg.compat) begin
      next_s.reset_conn = s.rs_q2 & s.cfg.cds_en;
    end else begin
      if (pixel) begin
        next_s.rs_arm = 1'b1;
      end else if (fall && s.rs_arm) begin
        next_s.rs_arm = 1'b0;
        next_s.reset_conn = s.cfg.cds_en;
      end else if (fall) begin
        next_s.reset_conn = 1'b0;
      end
    end

    if (s.cfg.mode == vss_pkg::MODE_LINE && s.cfg.autocyc && s.rs_q2 && !s.rs_prev) begin
      next_s.line_set = (s.line_set == vss_pkg::CH_BLUE) ? vss_pkg::CH_RED
                        : 2'(s.line_set + 2'h1);
    end

    idle = (s.slots_left == 2'h0) & ~s.fall_pend & ~s.vs_q2;
    if (idle) begin
      next_s.mono_active = s.cfg.mono_sel;
    end

    // Conversion slot sequencing
    next_s.conv_act = 1'b0;
    if (adv) begin
      if (pixel) begin
        unique case (s.cfg.mode)
          vss_pkg::MODE_PIXEL3: begin
            ch = vss_pkg::CH_RED;
            next_s.slots_left = 2'h2;
          end
          vss_pkg::MODE_TWO: begin
            ch = vss_pkg::CH_RED;
            next_s.slots_left = 2'h1;
          end
          vss_pkg::MODE_MONO: begin
            ch = s.mono_active;
            next_s.slots_left = 2'h0;
          end
          vss_pkg::MODE_LINE: begin
            ch = vss_pkg::CH_RED;
            next_s.slots_left = 2'h0;
          end
        endcase
        next_s.next_ch = 2'(ch + 2'h1);
        next_s.conv_act = 1'b1;
      end else if (s.slots_left != 2'h0) begin
        ch = s.next_ch;
        next_s.next_ch = 2'(s.next_ch + 2'h1);
        next_s.slots_left = 2'(s.slots_left - 2'h1);
        next_s.conv_act = 1'b1;
      end
      // Held until the next step captures the result
      next_s.conv_busy = next_s.conv_act;
      next_s.conv_ch = ch;
      set = (s.cfg.mode == vss_pkg::MODE_LINE)
            ? (s.cfg.autocyc ? s.line_set : s.cfg.manual_set) : ch;
      // Unused set code falls back to red
      if (set == 2'h3) begin
        set = vss_pkg::CH_RED;
      end
      next_s.gain_c = s.gain[set];
      next_s.offset_c = s.offset[set];

      // seven-stage latency line
      // Slot carries the previous step's result
      slot.valid = s.conv_busy;
      slot.ch = s.conv_ch;
      slot.data = adc_result;
      next_s.pipe = {s.pipe[vss_pkg::LATENCY_MCLK-2:0], slot};

      next_s.dvalid = s.pipe[vss_pkg::LATENCY_MCLK-2].valid;
      next_s.dch = s.pipe[vss_pkg::LATENCY_MCLK-2].ch;
      next_s.dout = s.pipe[vss_pkg::LATENCY_MCLK-2].data[15:8];
      next_s.low_byte = s.pipe[vss_pkg::LATENCY_MCLK-2].data[7:0];
    end else if (fall) begin
      next_s.dout = s.low_byte;
    end

    // Channel power-down
    unique case (s.cfg.mode)
      vss_pkg::MODE_PIXEL3: next_s.pdown = 3'h0;
      vss_pkg::MODE_TWO: next_s.pdown = 3'h4;
      vss_pkg::MODE_MONO: next_s.pdown = 3'(~(3'h1 << s.mono_active));
      vss_pkg::MODE_LINE: next_s.pdown = 3'h6;
    endcase

    // Register reads
    if (reg_read) begin
      unique case (reg_addr)
        vss_pkg::ADDR_CONTROL: next_s.rdata = 32'(s.cfg);
        vss_pkg::ADDR_STATUS: next_s.rdata = {26'h0, s.dvalid, ~s.por_q2,
                                              s.mono_active, s.line_set};
        vss_pkg::ADDR_OFFSET_RED: next_s.rdata = {24'h0, s.offset[0]};
        vss_pkg::ADDR_OFFSET_GREEN: next_s.rdata = {24'h0, s.offset[1]};
        vss_pkg::ADDR_OFFSET_BLUE: next_s.rdata = {24'h0, s.offset[2]};
        vss_pkg::ADDR_GAIN_RED: next_s.rdata = {23'h0, s.gain[0]};
        vss_pkg::ADDR_GAIN_GREEN: next_s.rdata = {23'h0, s.gain[1]};
        vss_pkg::ADDR_GAIN_BLUE: next_s.rdata = {23'h0, s.gain[2]};
        default: next_s.rdata = 32'h0;
      endcase
    end else begin
      next_s.rdata = 32'h0;
    end

    // Register writes
    next_s.soft_rst = 1'b0;
    if (reg_write && s.por_q2) begin
      unique case (reg_addr)
        vss_pkg::ADDR_SOFT_RESET: next_s.soft_rst = 1'b1;
        vss_pkg::ADDR_CONTROL: next_s.cfg = vss_pkg::vss_cfg_t'(reg_wdata[8:0]);
        vss_pkg::ADDR_OFFSET_RED: next_s.offset[0] = reg_wdata[7:0];
        vss_pkg::ADDR_OFFSET_GREEN: next_s.offset[1] = reg_wdata[7:0];
        vss_pkg::ADDR_OFFSET_BLUE: next_s.offset[2] = reg_wdata[7:0];
        vss_pkg::ADDR_GAIN_RED: next_s.gain[0] = reg_wdata[8:0];
        vss_pkg::ADDR_GAIN_GREEN: next_s.gain[1] = reg_wdata[8:0];
        vss_pkg::ADDR_GAIN_BLUE: next_s.gain[2] = reg_wdata[8:0];
        default: next_s.soft_rst = 1'b0;
      endcase
    end

    reg_rst = ~s.por_q2 | s.soft_rst;
    if (reg_rst) begin
      next_s.cfg = vss_pkg::CFG_RST;
      next_s.offset = {3{vss_pkg::OFFSET_RST}};
      next_s.gain = {3{vss_pkg::GAIN_RST}};
      next_s.line_set = vss_pkg::CH_RED;
      next_s.mono_active = vss_pkg::CFG_RST.mono_sel;
    end

    if (!rst_n) begin
      next_s = '0;
      next_s.cfg = vss_pkg::CFG_RST;
      next_s.offset = {3{vss_pkg::OFFSET_RST}};
      next_s.gain = {3{vss_pkg::GAIN_RST}};
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    s <= next_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s.rdata;
  assign video_cap_connect = s.video_conn;
  assign reset_cap_connect = s.reset_conn;
  assign conv_active = s.conv_act;
  assign conv_channel = s.conv_ch;
  assign gain_code = s.gain_c;
  assign offset_code = s.offset_c;
  assign power_down = s.pdown;
  assign data_out = s.dout;
  assign data_valid = s.dvalid;
  assign data_channel = s.dch;

endmodule

`default_nettype wire

// >>> sim/vss_sequencer_checker.sv
`timescale 1ns/100ps
`default_nettype none

module vss_sequencer_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Watched ports
  input wire logic video_sample_strobe,
  input wire logic reset_sample_strobe,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic video_cap_connect,
  input wire logic reset_cap_connect,
  input wire logic conv_active,
  input wire logic data_valid
);
  localparam int LAT_LO = 111;
  localparam int LAT_HI = 113;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_vs_low;
    (!video_sample_strobe) [*5];
  endsequence
  sequence s_conv_gap;
    (!conv_active) [*3];
  endsequence

  property p_vcap_on;
    $rose(video_sample_strobe) |-> ##[1:4] video_cap_connect;
  endproperty
  a_vcap_on: assert property (p_vcap_on)
    else $error("video cap not connected");
  property p_vcap_off;
    $fell(video_sample_strobe) |-> ##[1:4] !video_cap_connect;
  endproperty
  a_vcap_off: assert property (p_vcap_off)
    else $error("video cap not released");
  property p_vcap_idle;
    s_vs_low |-> !video_cap_connect;
  endproperty
  a_vcap_idle: assert property (p_vcap_idle)
    else $error("video cap on with strobe low");
  property p_rcap_off;
    $fell(reset_sample_strobe) |-> ##[1:4] !reset_cap_connect;
  endproperty
  a_rcap_off: assert property (p_rcap_off)
    else $error("reset cap not released");
  property p_caps_apart;
    !(video_cap_connect && reset_cap_connect);
  endproperty
  a_caps_apart: assert property (p_caps_apart)
    else $error("both caps connected");
  property p_conv_once;
    conv_active |=> s_conv_gap;
  endproperty
  a_conv_once: assert property (p_conv_once)
    else $error("step seen twice");
  property p_latency;
    conv_active |-> ##[LAT_LO:LAT_HI] data_valid;
  endproperty
  a_latency: assert property (p_latency)
    else $error("result late or missing");
  property p_rdata_idle;
    !$past(reg_read) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
endmodule

`default_nettype wire

// >>> sim/vss_scan_model.sv
`timescale 1ns/100ps
`default_nettype none

module vss_scan_model (
  // Clock and control
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic rs_en,
  // Pins
  output logic mclk,
  output logic video_sample_strobe,
  output logic reset_sample_strobe
);
  logic [3:0] ph;
  logic [1:0] pc;
  logic act;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ph <= 4'h0;
      pc <= 2'h0;
      act <= 1'b0;
    end else begin
      ph <= ph + 4'h1;
      if (ph == 4'hF) begin
        pc <= (pc == 2'h2) ? 2'h0 : pc + 2'h1;
        if (pc == 2'h2)
          act <= run;
      end
    end
  end

  assign mclk = ~ph[3];
  assign video_sample_strobe = act && pc == 2'h0 && ph >= 4'h1 && ph <= 4'hB;
  assign reset_sample_strobe = act && rs_en && pc == 2'h1 && ph >= 4'h9 && ph <= 4'hD;
endmodule

`default_nettype wire

// >>> sim/vss_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module vss_sequencer_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic power_on_reset_n = 1'b0;
  logic run = 1'b0;
  logic rs_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] adc_result = 16'hA5C3;
  logic [31:0] reg_rdata;
  logic mclk, video_sample_strobe, reset_sample_strobe;
  logic video_cap_connect, reset_cap_connect, conv_active, data_valid;
  logic [1:0] conv_channel;
  logic [8:0] gain_code;
  logic [7:0] offset_code, data_out;
  logic [2:0] power_down;
  logic [3:0] mc = 4'h0;
  logic mq = 1'b0;
  logic [8:0] gn [3] = '{9'h011, 9'h122, 9'h0F3};
  logic [7:0] of [3] = '{8'h10, 8'h21, 8'h32};
  logic [8:0] ctl [6] = '{9'h050, 9'h051, 9'h05A, 9'h053, 9'h040, 9'h113};
  logic [2:0] pdx [6] = '{3'h0, 3'h4, 3'h3, 3'h6, 3'h0, 3'h6};
  int nch [6] = '{3, 2, 1, 1, 3, 1};
  logic [1:0] chs [64];
  logic [15:0] dq [64];
  logic [15:0] cur = 16'h0;
  logic [1:0] data_channel;
  int wp = 0;
  int rp = 0;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int k = 0;
  int m = 0;
  int ech, gi;

  vss_sequencer u_vss_sequencer (.clock, .rst_n, .mclk, .video_sample_strobe,
    .reset_sample_strobe, .power_on_reset_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .adc_result, .video_cap_connect, .reset_cap_connect,
    .conv_active, .conv_channel, .gain_code, .offset_code, .power_down,
    .data_out, .data_valid, .data_channel);
  vss_scan_model u_vss_scan_model (.clock, .rst_n, .run, .rs_en, .mclk,
    .video_sample_strobe, .reset_sample_strobe);

  initial forever #2.5 clock = ~clock;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    chk(reg_rdata, exp);
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ------
  // Output monitor
  // ------
  always @(posedge clock) begin
    cyc++;
    mq <= mclk;
    mc <= (mq != mclk) ? 4'h0 : mc + 4'h1;
    if (data_valid && mc == 4'h6 && mclk) begin
      cur = dq[rp % 64];
      chk(data_channel, chs[rp % 64]);
      chk(data_out, cur[15:8]);
      rp++;
    end else if (data_valid && mc == 4'h6) begin
      chk(data_out, cur[7:0]);
    end
    if (conv_active) begin
      ech = (m == 2) ? 2 : (m == 3 || m == 5) ? 0 : k % nch[m];
      gi = (m == 3) ? k % 3 : (m == 5) ? 2 : ech;
      chk(conv_channel, ech);
      chk(gain_code, gn[gi]);
      chk(offset_code, of[gi]);
      chs[wp % 64] = 2'(ech);
      dq[wp % 64] = 16'hA5C3 ^ 16'(wp * 32'h0111);
      adc_result <= dq[wp % 64];
      wp++;
      k++;
    end
    if (cyc == 6000) begin
      mismatches++;
      end_sim();
    end
  end

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    wr(vss_pkg::ADDR_CONTROL, 32'h3);
    rd(vss_pkg::ADDR_CONTROL, {23'h0, vss_pkg::CFG_RST});
    rd(vss_pkg::ADDR_STATUS, 32'h10);
    power_on_reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(vss_pkg::ADDR_OFFSET_RED, 32'h80);
    rd(vss_pkg::ADDR_CONTROL, {23'h0, vss_pkg::CFG_RST});
    rd(8'hFC, 32'h0);
    $display("test power_on done");
    for (m = 0; m < 6; m++) begin
      wr(vss_pkg::ADDR_SOFT_RESET, 32'h1);
      for (int c = 0; c < 3; c++) begin
        wr(vss_pkg::ADDR_GAIN_RED + 8'(4 * c), 32'(gn[c]));
        wr(vss_pkg::ADDR_OFFSET_RED + 8'(4 * c), 32'(of[c]));
      end
      wr(vss_pkg::ADDR_CONTROL, 32'(ctl[m]));
      rs_en <= (m != 4);
      repeat (4) @(posedge clock);
      chk(power_down, pdx[m]);
      k = 0;
      run <= 1'b1;
      repeat (144) @(posedge clock);
      run <= 1'b0;
      repeat (200) @(posedge clock);
      chk(k, 3 * nch[m]);
      chk(rp, wp);
      $display("test mode %0d done", m);
    end
    wr(vss_pkg::ADDR_SOFT_RESET, 32'h1);
    rd(vss_pkg::ADDR_GAIN_BLUE, 32'h0);
    rd(vss_pkg::ADDR_CONTROL, {23'h0, vss_pkg::CFG_RST});
    $display("test soft_reset done");
    end_sim();
  end
endmodule

bind vss_sequencer vss_sequencer_checker u_vss_sequencer_checker (.clock, .rst_n,
  .video_sample_strobe, .reset_sample_strobe, .reg_read, .reg_rdata,
  .video_cap_connect, .reset_cap_connect, .conv_active, .data_valid);

`default_nettype wire
